// [inc/tkc_defs.svh]
`ifndef TKC_DEFS_SVH
`define TKC_DEFS_SVH

// Register byte offsets on the AXI4-Lite bus
`define TKC_ADDR_W        6
`define TKC_OFF_CF_HIGH   6'h00
`define TKC_OFF_CF_LOW    6'h04
`define TKC_OFF_AUX_LOW   6'h08
`define TKC_OFF_CAP       6'h0C
`define TKC_OFF_SENSE     6'h10
`define TKC_OFF_KEYPIN    6'h14
`define TKC_OFF_CTL       6'h18
`define TKC_OFF_OVF       6'h1C
`define TKC_OFF_SUPPLY    6'h20

// Reset values
`define TKC_RST_ZERO      8'h00
`define TKC_RST_CAP       8'h01

// measure_control fields
`define TKC_CTL_CF_EN     7
`define TKC_CTL_AUX_EN    6
`define TKC_CTL_START     5
`define TKC_CTL_REF_EN    4
`define TKC_CTL_REF_CLR   3
`define TKC_CTL_CF_CLR    2
`define TKC_CTL_AUX_CLR   1
`define TKC_CTL_SRC_SEL   0

// overflow_status fields
`define TKC_OVF_REF       5
`define TKC_OVF_CF        4
`define TKC_OVF_AUX       3

// supply_clock_power fields and writable mask
`define TKC_SUP_MASK      8'h71
`define TKC_SUP_SEL_LSB   4
`define TKC_SUP_SUB_SEL   3'h7

// Fine frequency decode in kHz
`define TKC_FREQ_BASE     10'h190
`define TKC_FREQ_STEP     10'h019

// Window length: 64 counts at code zero
`define TKC_WIN_BASE      14'h0040
`define TKC_MSB_SHIFT     4'h3

// AXI responses
`define TKC_RESP_OKAY     2'b00
`define TKC_RESP_SLVERR   2'b10

`endif

// [inc/tkc_pkg.sv]
package tkc_pkg;

    typedef enum logic [1:0] {
        TKC_WR_ADDR = 2'b01,
        TKC_WR_RESP = 2'b10
    } tkc_wr_e;

    typedef enum logic [1:0] {
        TKC_RD_ADDR = 2'b01,
        TKC_RD_DATA = 2'b10
    } tkc_rd_e;

endpackage : tkc_pkg

// [rtl/tkc_ref_window.sv]
`timescale 1ns/1ps
`include "tkc_defs.svh"

module tkc_ref_window
    import tkc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clr,
    input  wire logic        tick,
    input  wire logic [2:0]  win_sel,
    output logic             ovf,
    output logic [2:0]       hop_msbs
);

    logic [12:0] cnt_q;
    logic [12:0] cnt_d;
    logic [13:0] limit;
    logic [12:0] shifted;

    always_comb begin
        limit    = (`TKC_WIN_BASE << win_sel) - 14'h0001;
        ovf      = tick && !clr && (cnt_q == limit[12:0]);
        shifted  = cnt_q >> (`TKC_MSB_SHIFT + {1'b0, win_sel});
        hop_msbs = shifted[2:0];
        cnt_d    = cnt_q;
        if (clr) begin
            cnt_d = 13'h0000;
        end else if (ovf) begin
            cnt_d = 13'h0000;
        end else if (tick) begin
            cnt_d = cnt_q + 13'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 13'h0000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    a_window_end: assert property (@(posedge aclk) disable iff (!aresetn)
        ovf |-> cnt_q == limit[12:0] && limit[13] == 1'b0)
        else $error("Window ended off its length");

    a_ref_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        clr |=> cnt_q == 13'h0000)
        else $error("Reference counter not cleared");

endmodule : tkc_ref_window

// [rtl/tkc_top.sv]
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "tkc_defs.svh"
module tkc_top
    import tkc_pkg::*;
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [`TKC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`TKC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [3:0]             key_osc_in,
    input  wire logic                   ref_osc_in,
    input  wire logic                   sub_clk_in,
    input  wire logic                   touch_irq_enable,
    input  wire logic                   global_irq_enable,
    input  wire logic                   touch_irq_clear,
    output logic [1:0]                  key_mux_sel,
    output logic                        double_freq_en,
    output logic                        filter_en,
    output logic [2:0]                  fine_freq_code,
    output logic [9:0]                  sense_freq_khz,
    output logic [3:0]                  key_osc_en,
    output logic [3:0]                  key_touch_sel,
    output logic [7:0]                  osc_cap_select,
    output logic                        ref_clock_en,
    output logic                        output_clock_enable,
    output logic                        normal_mode,
    output logic                        touch_irq_request,
    output logic                        touch_irq
);

    function automatic logic addr_mapped(input logic [`TKC_ADDR_W-1:0] a);
        addr_mapped = (a <= `TKC_OFF_SUPPLY) && (a[1:0] == 2'b00);
    endfunction : addr_mapped

    function automatic logic [9:0] freq_khz(input logic [2:0] code);
        logic [9:0] step;
        step     = `TKC_FREQ_STEP * {7'h00, code};
        freq_khz = `TKC_FREQ_BASE + step;
    endfunction : freq_khz

    tkc_wr_e     wr_st_q, wr_st_d;
    tkc_rd_e     rd_st_q, rd_st_d;
    logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [`TKC_ADDR_W-1:0] waddr_q, waddr_d;
    logic [7:0]  wbyte_q, wbyte_d;
    logic        wlane_q, wlane_d;
    logic        awready_q, awready_d, wready_q, wready_d;
    logic        bvalid_q, bvalid_d, arready_q, arready_d;
    logic        rvalid_q, rvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [7:0]  cap_q, cap_d, sense_q, sense_d, key_q, key_d;
    logic [7:0]  ctl_q, ctl_d, sup_q, sup_d;
    logic [2:0]  win_q, win_d;
    logic        ref_ovf_q, ref_ovf_d, cf_ovf_q, cf_ovf_d;
    logic        aux_ovf_q, aux_ovf_d;
    logic [15:0] cf_cnt_q, cf_cnt_d;
    logic [9:0]  aux_cnt_q, aux_cnt_d;
    logic        output_clock_enable_q, output_clock_enable_d, rise_q, rise_d;
    logic        irq_req_q, irq_req_d, irq_q, irq_d;
    logic [2:0]  code_q, code_d;
    logic [9:0]  khz_q, khz_d;
    logic [5:0]  prev_q, prev_d;
    logic [6:0]  pre_q, pre_d;
    logic [5:0]  edges;
    logic [6:0]  pre_mask;
    logic        wr_fire, start_rise, sense_edge, sup_tick;
    logic        cf_tick, aux_tick, ref_tick, ref_clr, ref_ovf;
    logic [2:0]  hop_msbs;
    logic [7:0]  rd_byte;

    tkc_ref_window u_window (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clr      (ref_clr),
        .tick     (ref_tick),
        .win_sel  (win_q),
        .ovf      (ref_ovf),
        .hop_msbs (hop_msbs)
    );

    always_comb begin
        edges      = {sub_clk_in, ref_osc_in, key_osc_in} & ~prev_q;
        sense_edge = edges[sense_q[7:6]];
        pre_mask   = 7'((8'h02 << sup_q[6:4]) - 8'h01);
        sup_tick   = (sup_q[6:4] == `TKC_SUP_SUB_SEL) ? edges[5]
                   : ((pre_q & pre_mask) == pre_mask);
        cf_tick    = output_clock_enable_q && ctl_q[`TKC_CTL_CF_EN] && sense_edge;
        aux_tick   = output_clock_enable_q && ctl_q[`TKC_CTL_AUX_EN] && sup_tick;
        ref_tick   = output_clock_enable_q && ctl_q[`TKC_CTL_REF_EN]
                   && (ctl_q[`TKC_CTL_SRC_SEL] ? edges[3] : edges[4]);
        ref_clr    = ctl_q[`TKC_CTL_REF_CLR] || rise_q;
        case (s_axi_araddr)
            `TKC_OFF_CF_HIGH: rd_byte = cf_cnt_q[15:8];
            `TKC_OFF_CF_LOW:  rd_byte = cf_cnt_q[7:0];
            `TKC_OFF_AUX_LOW: rd_byte = aux_cnt_q[7:0];
            `TKC_OFF_CAP:     rd_byte = cap_q;
            `TKC_OFF_SENSE:   rd_byte = sense_q;
            `TKC_OFF_KEYPIN:  rd_byte = key_q;
            `TKC_OFF_CTL:     rd_byte = ctl_q;
            `TKC_OFF_OVF:     rd_byte = {aux_cnt_q[9:8], ref_ovf_q,
                                         cf_ovf_q, aux_ovf_q, win_q};
            `TKC_OFF_SUPPLY:  rd_byte = sup_q;
            default:          rd_byte = `TKC_RST_ZERO;
        endcase
    end

    // Bus handshakes
    always_comb begin
        wr_st_d   = wr_st_q;
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        waddr_d   = waddr_q;
        wbyte_d   = wbyte_q;
        wlane_d   = wlane_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rd_st_d   = rd_st_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        wr_fire   = 1'b0;
        case (wr_st_q)
            TKC_WR_ADDR: begin
                if (s_axi_awvalid && awready_q) begin
                    aw_have_d = 1'b1;
                    waddr_d   = s_axi_awaddr;
                end
                if (s_axi_wvalid && wready_q) begin
                    w_have_d = 1'b1;
                    wbyte_d  = s_axi_wdata[7:0];
                    wlane_d  = s_axi_wstrb[0];
                end
                if (aw_have_q && w_have_q) begin
                    wr_fire   = 1'b1;
                    aw_have_d = 1'b0;
                    w_have_d  = 1'b0;
                    bvalid_d  = 1'b1;
                    bresp_d   = addr_mapped(waddr_q) ? `TKC_RESP_OKAY
                                                     : `TKC_RESP_SLVERR;
                    wr_st_d   = TKC_WR_RESP;
                end
            end
            TKC_WR_RESP: begin
                if (s_axi_bready) begin
                    bvalid_d = 1'b0;
                    wr_st_d  = TKC_WR_ADDR;
                end
            end
            default: wr_st_d = TKC_WR_ADDR;
        endcase
        case (rd_st_q)
            TKC_RD_ADDR: begin
                if (s_axi_arvalid && arready_q) begin
                    rdata_d  = rd_byte;
                    rresp_d  = addr_mapped(s_axi_araddr) ? `TKC_RESP_OKAY
                                                         : `TKC_RESP_SLVERR;
                    rvalid_d = 1'b1;
                    rd_st_d  = TKC_RD_DATA;
                end
            end
            TKC_RD_DATA: begin
                if (s_axi_rready) begin
                    rvalid_d = 1'b0;
                    rd_st_d  = TKC_RD_ADDR;
                end
            end
            default: rd_st_d = TKC_RD_ADDR;
        endcase
        awready_d = (wr_st_d == TKC_WR_ADDR) && !aw_have_d;
        wready_d  = (wr_st_d == TKC_WR_ADDR) && !w_have_d;
        arready_d = (rd_st_d == TKC_RD_ADDR);
    end

    // Registers, counters and measurement window
    always_comb begin
        cap_d     = cap_q;
        sense_d   = sense_q;
        key_d     = key_q;
        sup_d     = sup_q;
        win_d     = win_q;
        ref_ovf_d = ref_ovf_q;
        cf_ovf_d  = cf_ovf_q;
        aux_ovf_d = aux_ovf_q;
        ctl_d     = ctl_q;
        ctl_d[`TKC_CTL_REF_CLR] = 1'b0;
        ctl_d[`TKC_CTL_CF_CLR]  = 1'b0;
        ctl_d[`TKC_CTL_AUX_CLR] = 1'b0;
        if (wr_fire && wlane_q) begin
            case (waddr_q)
                `TKC_OFF_CAP:    cap_d   = wbyte_q;
                `TKC_OFF_SENSE:  sense_d = wbyte_q;
                `TKC_OFF_KEYPIN: key_d   = wbyte_q;
                `TKC_OFF_CTL:    ctl_d   = wbyte_q;
                `TKC_OFF_OVF: begin
                    ref_ovf_d = wbyte_q[`TKC_OVF_REF];
                    cf_ovf_d  = wbyte_q[`TKC_OVF_CF];
                    aux_ovf_d = wbyte_q[`TKC_OVF_AUX];
                    win_d     = wbyte_q[2:0];
                end
                `TKC_OFF_SUPPLY: sup_d   = wbyte_q & `TKC_SUP_MASK;
                default:         cap_d   = cap_q;
            endcase
        end
        start_rise = ctl_d[`TKC_CTL_START] && !ctl_q[`TKC_CTL_START];
        rise_d     = start_rise;
        output_clock_enable_d     = output_clock_enable_q;
        irq_req_d  = irq_req_q && !touch_irq_clear;
        if (start_rise) begin
            output_clock_enable_d    = 1'b1;
            ref_ovf_d = 1'b0;
        end
        if (!ctl_d[`TKC_CTL_START]) begin
            output_clock_enable_d = 1'b0;
        end
        if (ref_ovf) begin
            ref_ovf_d = 1'b1;
            output_clock_enable_d    = 1'b0;
            irq_req_d = 1'b1;
            ctl_d[`TKC_CTL_CF_EN]  = 1'b0;
            ctl_d[`TKC_CTL_AUX_EN] = 1'b0;
        end
        cf_cnt_d = cf_cnt_q;
        if (ctl_q[`TKC_CTL_CF_CLR]) begin
            cf_cnt_d = 16'h0000;
        end else if (cf_tick) begin
            cf_cnt_d = cf_cnt_q + 16'h0001;
            if (cf_cnt_q == 16'hFFFF) begin
                cf_ovf_d = 1'b1;
            end
        end
        aux_cnt_d = aux_cnt_q;
        if (ctl_q[`TKC_CTL_AUX_CLR]) begin
            aux_cnt_d = 10'h000;
        end else if (aux_tick) begin
            aux_cnt_d = aux_cnt_q + 10'h001;
            if (aux_cnt_q == 10'h3FF) begin
                aux_ovf_d = 1'b1;
            end
        end
        irq_d  = irq_req_q && touch_irq_enable && global_irq_enable;
        code_d = sense_d[3] ? hop_msbs : sense_d[2:0];
        khz_d  = freq_khz(code_d);
        prev_d = {sub_clk_in, ref_osc_in, key_osc_in};
        pre_d  = pre_q + 7'h01;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_st_q   <= TKC_WR_ADDR;
            rd_st_q   <= TKC_RD_ADDR;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            waddr_q   <= `TKC_OFF_CF_HIGH;
            wbyte_q   <= `TKC_RST_ZERO;
            wlane_q   <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            rvalid_q  <= 1'b0;
            bresp_q   <= `TKC_RESP_OKAY;
            rresp_q   <= `TKC_RESP_OKAY;
            rdata_q   <= `TKC_RST_ZERO;
            cap_q     <= `TKC_RST_CAP;
            sense_q   <= `TKC_RST_ZERO;
            key_q     <= `TKC_RST_ZERO;
            ctl_q     <= `TKC_RST_ZERO;
            sup_q     <= `TKC_RST_ZERO;
            win_q     <= 3'h0;
            ref_ovf_q <= 1'b0;
            cf_ovf_q  <= 1'b0;
            aux_ovf_q <= 1'b0;
            cf_cnt_q  <= 16'h0000;
            aux_cnt_q <= 10'h000;
            output_clock_enable_q    <= 1'b0;
            rise_q    <= 1'b0;
            irq_req_q <= 1'b0;
            irq_q     <= 1'b0;
            code_q    <= 3'h0;
            khz_q     <= `TKC_FREQ_BASE;
            prev_q    <= 6'h00;
            pre_q     <= 7'h00;
        end else begin
            wr_st_q   <= wr_st_d;
            rd_st_q   <= rd_st_d;
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            waddr_q   <= waddr_d;
            wbyte_q   <= wbyte_d;
            wlane_q   <= wlane_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
            bvalid_q  <= bvalid_d;
            rvalid_q  <= rvalid_d;
            bresp_q   <= bresp_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            cap_q     <= cap_d;
            sense_q   <= sense_d;
            key_q     <= key_d;
            ctl_q     <= ctl_d;
            sup_q     <= sup_d;
            win_q     <= win_d;
            ref_ovf_q <= ref_ovf_d;
            cf_ovf_q  <= cf_ovf_d;
            aux_ovf_q <= aux_ovf_d;
            cf_cnt_q  <= cf_cnt_d;
            aux_cnt_q <= aux_cnt_d;
            output_clock_enable_q    <= output_clock_enable_d;
            rise_q    <= rise_d;
            irq_req_q <= irq_req_d;
            irq_q     <= irq_d;
            code_q    <= code_d;
            khz_q     <= khz_d;
            prev_q    <= prev_d;
            pre_q     <= pre_d;
        end
    end

    assign s_axi_awready       = awready_q;
    assign s_axi_wready        = wready_q;
    assign s_axi_bvalid        = bvalid_q;
    assign s_axi_bresp         = bresp_q;
    assign s_axi_arready       = arready_q;
    assign s_axi_rvalid        = rvalid_q;
    assign s_axi_rresp         = rresp_q;
    assign s_axi_rdata         = {24'h00_0000, rdata_q};
    assign key_mux_sel         = sense_q[7:6];
    assign double_freq_en      = sense_q[5];
    assign filter_en           = sense_q[4];
    assign fine_freq_code      = code_q;
    assign sense_freq_khz      = khz_q;
    assign key_osc_en          = key_q[7:4];
    assign key_touch_sel       = key_q[3:0];
    assign osc_cap_select      = cap_q;
    assign ref_clock_en        = ctl_q[`TKC_CTL_REF_EN];
    assign output_clock_enable = output_clock_enable_q;
    assign normal_mode         = sup_q[0];
    assign touch_irq_request   = irq_req_q;
    assign touch_irq           = irq_q;

    a_start_opens: assert property (@(posedge aclk) disable iff (!aresetn)
        rise_q && !$past(ref_ovf) |-> output_clock_enable_q && !ref_ovf_q)
        else $error("Start rise did not open the window");

    a_start_low: assert property (@(posedge aclk) disable iff (!aresetn)
        !ctl_q[`TKC_CTL_START] |-> !output_clock_enable_q && !ref_tick)
        else $error("Clock enabled while start is low");

    a_ovf_effects: assert property (@(posedge aclk) disable iff (!aresetn)
        ref_ovf |=> ref_ovf_q && !output_clock_enable_q && irq_req_q)
        else $error("Window overflow effects missing");

    a_ovf_stops_cnt: assert property (@(posedge aclk) disable iff (!aresetn)
        ref_ovf |=> !ctl_q[`TKC_CTL_CF_EN] && !ctl_q[`TKC_CTL_AUX_EN])
        else $error("Counter enables survived overflow");

    a_irq_gating: assert property (@(posedge aclk) disable iff (!aresetn)
        touch_irq == $past(irq_req_q && touch_irq_enable
                           && global_irq_enable))
        else $error("Interrupt output not gated correctly");

    a_cf_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        ctl_q[`TKC_CTL_CF_CLR] |=> cf_cnt_q == 16'h0000)
        else $error("Capacitance counter not cleared");

    a_cf_counts: assert property (@(posedge aclk) disable iff (!aresetn)
        cf_tick && !ctl_q[`TKC_CTL_CF_CLR]
        |=> cf_cnt_q == $past(cf_cnt_q) + 16'h0001)
        else $error("Capacitance counter missed an edge");

    a_freq_decode: assert property (@(posedge aclk) disable iff (!aresetn)
        sense_freq_khz == 10'h190 + 10'h019 * {7'h00, fine_freq_code})
        else $error("Frequency decode mismatch");

    a_soft_freq: assert property (@(posedge aclk) disable iff (!aresetn)
        !sense_q[3] |-> fine_freq_code == sense_q[2:0])
        else $error("Software frequency not applied");

endmodule : tkc_top

// [test/tkc_top_bench.sv]
`timescale 1ns/1ps
`include "tkc_defs.svh"
module tkc_top_bench;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, ref_osc_in;
    logic        sub_clk_in, touch_irq_enable, global_irq_enable;
    logic        touch_irq_clear, double_freq_en, filter_en, ref_clock_en;
    logic        normal_mode, output_clock_enable, touch_irq_request;
    logic        touch_irq;
    logic [5:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb, key_osc_in, key_osc_en, key_touch_sel;
    logic [1:0]  s_axi_bresp, s_axi_rresp, key_mux_sel, rsp;
    logic [2:0]  fine_freq_code;
    logic [9:0]  sense_freq_khz;
    logic [7:0]  osc_cap_select;
    int          failures, checks, cyc;

    tkc_top dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .key_osc_in(key_osc_in),
        .ref_osc_in(ref_osc_in), .sub_clk_in(sub_clk_in),
        .touch_irq_enable(touch_irq_enable),
        .global_irq_enable(global_irq_enable),
        .touch_irq_clear(touch_irq_clear), .key_mux_sel(key_mux_sel),
        .double_freq_en(double_freq_en), .filter_en(filter_en),
        .fine_freq_code(fine_freq_code), .sense_freq_khz(sense_freq_khz),
        .key_osc_en(key_osc_en), .key_touch_sel(key_touch_sel),
        .osc_cap_select(osc_cap_select), .ref_clock_en(ref_clock_en),
        .output_clock_enable(output_clock_enable),
        .normal_mode(normal_mode), .touch_irq_request(touch_irq_request),
        .touch_irq(touch_irq));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    // Hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 12000) begin
            failures++;
            summarize();
        end
    end

    task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
        checks++;
        if (got !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, got);
        end
    endtask : chk

    task wr(input logic [5:0] a, input logic [7:0] d);
        logic b;
        b = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                rsp = s_axi_bresp;
                b = 1'b1;
            end
        end
        s_axi_bready <= 1'b0;
    endtask : wr

    task rdr(input logic [5:0] a);
        logic b;
        b = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!b) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rd = s_axi_rdata;
                rsp = s_axi_rresp;
                b = 1'b1;
            end
        end
        s_axi_rready <= 1'b0;
    endtask : rdr

    task rc(input string nm, input logic [5:0] a, input logic [7:0] m,
            input logic [7:0] e);
        rdr(a);
        chk(nm, rd & {24'h00_0000, m}, {24'h00_0000, e});
    endtask : rc

    // Source 4 is the reference oscillator, 0..3 the keys
    task pulse(input int k, input int n);
        repeat (n) begin
            @(posedge aclk);
            if (k == 4) ref_osc_in <= 1'b1; else key_osc_in[k] <= 1'b1;
            repeat (2) @(posedge aclk);
            if (k == 4) ref_osc_in <= 1'b0; else key_osc_in[k] <= 1'b0;
            @(posedge aclk);
        end
    endtask : pulse

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, ref_osc_in, sub_clk_in} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {key_osc_in, touch_irq_clear} = '0;
        {s_axi_wstrb, touch_irq_enable, global_irq_enable} = 6'h3F;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rc("cf_high", `TKC_OFF_CF_HIGH, 8'hFF, 8'h00);
        rc("cf_low", `TKC_OFF_CF_LOW, 8'hFF, 8'h00);
        rc("aux_low", `TKC_OFF_AUX_LOW, 8'hFF, 8'h00);
        rc("cap", `TKC_OFF_CAP, 8'hFF, 8'h01);
        rc("ctl", `TKC_OFF_CTL, 8'hFF, 8'h00);
        rdr(6'h24);
        chk("unmapped", rsp, `TKC_RESP_SLVERR);
        wr(`TKC_OFF_CF_HIGH, 8'hFF);
        rc("cf_high_ro", `TKC_OFF_CF_HIGH, 8'hFF, 8'h00);
        wr(`TKC_OFF_SUPPLY, 8'hFF);
        rc("supply", `TKC_OFF_SUPPLY, 8'hFF, 8'h71);
        chk("normal_mode", normal_mode, 1'b1);
        wr(`TKC_OFF_CAP, 8'h80);
        chk("cap_out", osc_cap_select, 8'h80);
        rc("cap_back", `TKC_OFF_CAP, 8'hFF, 8'h80);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wr(`TKC_OFF_SENSE, {i[1:0], 3'b000, i[2:0]});
            chk("key_mux_sel", key_mux_sel, i % 4);
            chk("fine_code", fine_freq_code, i);
            chk("freq_khz", sense_freq_khz, 400 + 25 * i);
        end
        wr(`TKC_OFF_SENSE, 8'hB0);
        chk("dbl_freq", double_freq_en, 1'b1);
        chk("filter", filter_en, 1'b1);
        wr(`TKC_OFF_KEYPIN, 8'hA5);
        chk("key_osc_en", key_osc_en, 4'hA);
        chk("touch_sel", key_touch_sel, 4'h5);
        $display("test config done");
        wr(`TKC_OFF_CTL, 8'hE0);
        chk("output_clock_enable_start", output_clock_enable, 1'b1);
        pulse(4, 70);
        chk("output_clock_enable_refoff", output_clock_enable, 1'b1);
        pulse(2, 10);
        pulse(0, 5);
        rc("cf_count", `TKC_OFF_CF_LOW, 8'hFF, 8'h0A);
        rc("cf_reread", `TKC_OFF_CF_LOW, 8'hFF, 8'h0A);
        wr(`TKC_OFF_CTL, 8'hF0);
        chk("ref_clk_en", ref_clock_en, 1'b1);
        pulse(4, 64);
        repeat (6) @(posedge aclk);
        chk("output_clock_enable_ovf", output_clock_enable, 1'b0);
        chk("irq_req", touch_irq_request, 1'b1);
        chk("irq", touch_irq, 1'b1);
        rc("ctl_ovf", `TKC_OFF_CTL, 8'hFF, 8'h30);
        rc("ref_flag", `TKC_OFF_OVF, 8'h3F, 8'h20);
        wr(`TKC_OFF_CTL, 8'h34);
        rc("cf_clr", `TKC_OFF_CF_LOW, 8'hFF, 8'h00);
        rc("clr_self", `TKC_OFF_CTL, 8'hFF, 8'h30);
        $display("test window done");
        @(posedge aclk);
        touch_irq_clear <= 1'b1;
        global_irq_enable <= 1'b0;
        @(posedge aclk);
        touch_irq_clear <= 1'b0;
        wr(`TKC_OFF_CTL, 8'h10);
        chk("output_clock_enable_stop", output_clock_enable, 1'b0);
        pulse(4, 70);
        chk("irq_idle", touch_irq_request, 1'b0);
        wr(`TKC_OFF_OVF, 8'h21);
        wr(`TKC_OFF_CTL, 8'h31);
        chk("output_clock_enable_rerun", output_clock_enable, 1'b1);
        rc("flag_clr", `TKC_OFF_OVF, 8'h3F, 8'h01);
        pulse(4, 70);
        chk("output_clock_enable_src", output_clock_enable, 1'b1);
        pulse(3, 127);
        chk("output_clock_enable_127", output_clock_enable, 1'b1);
        pulse(3, 1);
        repeat (6) @(posedge aclk);
        chk("output_clock_enable_128", output_clock_enable, 1'b0);
        chk("irq_req2", touch_irq_request, 1'b1);
        chk("irq_masked", touch_irq, 1'b0);
        wr(`TKC_OFF_OVF, 8'h00);
        wr(`TKC_OFF_CTL, 8'h10);
        wr(`TKC_OFF_CTL, 8'h30);
        pulse(4, 40);
        wr(`TKC_OFF_CTL, 8'h38);
        rc("refclr_self", `TKC_OFF_CTL, 8'hFF, 8'h30);
        pulse(4, 40);
        chk("output_clock_enable_refclr", output_clock_enable, 1'b1);
        wr(`TKC_OFF_SENSE, 8'h08);
        chk("hop_code", fine_freq_code, 3'h5);
        chk("hop_khz", sense_freq_khz, 10'd525);
        pulse(4, 24);
        repeat (6) @(posedge aclk);
        chk("output_clock_enable_64", output_clock_enable, 1'b0);
        $display("test interrupt done");
        wr(`TKC_OFF_SUPPLY, 8'h01);
        wr(`TKC_OFF_CTL, 8'h10);
        wr(`TKC_OFF_CTL, 8'h60);
        repeat (600) @(posedge aclk);
        rc("aux_bits98", `TKC_OFF_OVF, 8'hC0, 8'h40);
        repeat (1600) @(posedge aclk);
        rc("aux_ovf", `TKC_OFF_OVF, 8'h08, 8'h08);
        wr(`TKC_OFF_CTL, 8'h00);
        wr(`TKC_OFF_OVF, 8'h00);
        rc("aux_ovf_clr", `TKC_OFF_OVF, 8'h08, 8'h00);
        $display("test aux done");
        summarize();
    end
endmodule : tkc_top_bench
